/* rtl/src_dma_route.sv */
`timescale 1ns/10ps
`default_nettype none
// one request line routed to one of two channel numbers
module src_dma_route
    import src_pkg::*;
#(
    parameter logic [2:0] CH_CLEAR = 3'h1,
    parameter logic [2:0] CH_SET = 3'h2
) (
    input wire logic remap_i,
    output logic [2:0] channel_o
);
    // choose channel by remap bit
    assign channel_o = remap_i ? CH_SET : CH_CLEAR;
endmodule
`default_nettype wire

/* rtl/src_mem_decode.sv */
`timescale 1ns/10ps
`default_nettype none
// decodes the memory map select field
module src_mem_decode
    import src_pkg::*;
(
    input wire logic [1:0] map_i,
    output src_mem_t mem_o
);
    // low bit clear gives main flash
    always_comb
    begin
        case (map_i)
            2'h1: mem_o = SRC_MEM_SYS_FLASH;
            2'h3: mem_o = SRC_MEM_SRAM;
            default: mem_o = SRC_MEM_MAIN_FLASH;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/src_pkg.sv */
package src_pkg;
    // register byte offsets
    localparam logic [4:0] SRC_OFF_REMAP = 5'h00;
    localparam logic [4:0] SRC_OFF_EXTA = 5'h08;
    localparam logic [4:0] SRC_OFF_EXTB = 5'h0c;
    localparam logic [4:0] SRC_OFF_EXTC = 5'h10;
    localparam logic [4:0] SRC_OFF_EXTD = 5'h14;
    localparam logic [4:0] SRC_OFF_CFG2 = 5'h18;
    // writable bits of the remap register
    localparam logic [31:0] SRC_REMAP_MASK = 32'h7f3f7f03;
    localparam logic [31:0] SRC_EXT_MASK = 32'h0000ffff;
    localparam logic [31:0] SRC_REMAP_RST = 32'h00000000;
    localparam logic [31:0] SRC_EXT_RST = 32'h00000000;
    localparam logic [31:0] SRC_CFG2_RST = 32'h00000000;
    // field positions
    localparam int SRC_B_MAP = 0;
    localparam int SRC_B_CONV = 8;
    localparam int SRC_B_SER1_A = 9;
    localparam int SRC_B_SER1_B = 10;
    localparam int SRC_B_T16 = 11;
    localparam int SRC_B_T17 = 12;
    localparam int SRC_B_T16_ALT = 13;
    localparam int SRC_B_T17_ALT = 14;
    localparam int SRC_B_PIN_FP = 16;
    localparam int SRC_B_I2C1_FP = 20;
    localparam int SRC_B_I2C2_FP = 21;
    localparam int SRC_B_SPI2 = 24;
    localparam int SRC_B_SER2 = 25;
    localparam int SRC_B_SER3 = 26;
    localparam int SRC_B_I2C1 = 27;
    localparam int SRC_B_T1 = 28;
    localparam int SRC_B_T2 = 29;
    localparam int SRC_B_T3 = 30;
    // memory placed at address zero
    typedef enum logic [1:0] {
        SRC_MEM_MAIN_FLASH,
        SRC_MEM_SYS_FLASH,
        SRC_MEM_SRAM
    } src_mem_t;
    // bus slave phases
    typedef enum logic [1:0] {
        SRC_BUS_IDLE,
        SRC_BUS_ACK
    } src_bus_t;
endpackage

/* rtl/src_system_remap_config.sv */
// Operation
// - map field 1:0 picks main flash (x0), system flash (01) or SRAM (11).
// - reset clears the map field; the first clock after reset loads it from the boot pin levels.
// - all configuration bits are software writable, overriding boot mapping.
// - bit 8 routes converter request to channel 1 or 2.
// - bit 9 moves serial1 request on channel 2 to channel 4.
// - bit 10 moves serial1 request on channel 3 to channel 5.
// - bit 11 routes timer16 requests to channel 3 or 4.
// - bit 12 routes timer17 requests to channel 1 or 2.
// - bit 13 forces timer16 requests to channel 6, else bit 11 applies.
// - bit 14 forces timer17 requests to channel 7, else bit 12 applies.
// - bits 16..19 enable fast-mode-plus drive on pins B6..B9.
// - bits 20,21 let all first/second i2c pins use fast-mode-plus.
// - bit 24 routes spi2 rx/tx to channels 4/5 or 6/7.
// - bit 25 routes serial2 rx/tx to channels 5/4 or 6/7.
// - bit 26 routes serial3 rx/tx to channels 6/7 or 3/2.
// - bit 27 routes first i2c rx/tx to channels 3/2 or 7/6.
// - bit 28 routes timer1 ch1..3 to channels 2/3/4 or all to 6.
// - bit 29 routes timer2 ch2/ch4 to channels 3/4 or both to 7.
// - bit 30 routes timer3 ch1 and trigger to channel 4 or 6.
`timescale 1ns/10ps
`default_nettype none
module src_system_remap_config
    import src_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] boot_map_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // memory map
    output src_mem_t mem_at_zero_o,
    // dma channel numbers per request
    output logic [2:0] conv_ch_o,
    output logic [2:0] ser1_a_ch_o,
    output logic [2:0] ser1_b_ch_o,
    output logic [2:0] t16_ch_o,
    output logic [2:0] t17_ch_o,
    output logic [2:0] spi2_rx_ch_o,
    output logic [2:0] spi2_tx_ch_o,
    output logic [2:0] ser2_rx_ch_o,
    output logic [2:0] ser2_tx_ch_o,
    output logic [2:0] ser3_rx_ch_o,
    output logic [2:0] ser3_tx_ch_o,
    output logic [2:0] i2c1_rx_ch_o,
    output logic [2:0] i2c1_tx_ch_o,
    output logic [2:0] t1_ch1_ch_o,
    output logic [2:0] t1_ch2_ch_o,
    output logic [2:0] t1_ch3_ch_o,
    output logic [2:0] t2_ch2_ch_o,
    output logic [2:0] t2_ch4_ch_o,
    output logic [2:0] t3_ch_o,
    // fast-mode-plus controls
    output logic [3:0] pin_b_fast_plus_o,
    output logic i2c_first_fast_plus_all_o,
    output logic i2c_second_fast_plus_all_o,
    // other configuration words
    output logic [31:0] ext_int_sel_o,
    output logic [31:0] cfg2_o
);
    typedef struct packed {
        src_bus_t bus;
        logic boot_done;
        logic [31:0] remap;
        logic [15:0] ext_a;
        logic [15:0] ext_b;
        logic [15:0] ext_c;
        logic [15:0] ext_d;
        logic [31:0] cfg2;
        logic [31:0] rdata;
    } src_state_t;

    src_state_t st;
    src_state_t next_st;
    logic [31:0] be_mask;
    logic [31:0] t16_base;
    logic [2:0] t16_plain;
    logic [2:0] t17_plain;

    // byte enables to bit mask
    always_comb
    begin
        be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end

    // bus handshake, boot capture and register updates
    always_comb
    begin
        next_st = st;
        t16_base = '0;
        if (!st.boot_done)
        begin
            next_st.remap[1:0] = boot_map_i;
            next_st.boot_done = 1'b1;
        end
        case (st.bus)
            SRC_BUS_IDLE:
            begin
                if (avs_write)
                begin
                    next_st.bus = SRC_BUS_ACK;
                    case (avs_address)
                        SRC_OFF_REMAP:
                        begin
                            t16_base = SRC_REMAP_MASK & be_mask;
                            next_st.remap = (st.remap & ~t16_base)
                                | (avs_writedata & t16_base);
                        end
                        SRC_OFF_EXTA: next_st.ext_a = wr16(st.ext_a);
                        SRC_OFF_EXTB: next_st.ext_b = wr16(st.ext_b);
                        SRC_OFF_EXTC: next_st.ext_c = wr16(st.ext_c);
                        SRC_OFF_EXTD: next_st.ext_d = wr16(st.ext_d);
                        SRC_OFF_CFG2:
                            next_st.cfg2 = (st.cfg2 & ~be_mask) | (avs_writedata & be_mask);
                        default: next_st.bus = SRC_BUS_ACK; // unmapped ignored
                    endcase
                end
                else if (avs_read)
                begin
                    next_st.bus = SRC_BUS_ACK;
                    case (avs_address)
                        SRC_OFF_REMAP: next_st.rdata = st.remap & SRC_REMAP_MASK;
                        SRC_OFF_EXTA: next_st.rdata = {16'h0000, st.ext_a};
                        SRC_OFF_EXTB: next_st.rdata = {16'h0000, st.ext_b};
                        SRC_OFF_EXTC: next_st.rdata = {16'h0000, st.ext_c};
                        SRC_OFF_EXTD: next_st.rdata = {16'h0000, st.ext_d};
                        SRC_OFF_CFG2: next_st.rdata = st.cfg2;
                        default: next_st.rdata = 32'h00000000;
                    endcase
                end
            end
            SRC_BUS_ACK: next_st.bus = SRC_BUS_IDLE;
            default: next_st.bus = SRC_BUS_IDLE;
        endcase
    end

    // masked 16-bit write helper
    function automatic logic [15:0] wr16(input logic [15:0] old);
        wr16 = (old & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
    endfunction

    // state register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st.bus <= SRC_BUS_IDLE;
            st.boot_done <= 1'b0;
            st.remap <= SRC_REMAP_RST;
            st.ext_a <= SRC_EXT_RST[15:0];
            st.ext_b <= SRC_EXT_RST[15:0];
            st.ext_c <= SRC_EXT_RST[15:0];
            st.ext_d <= SRC_EXT_RST[15:0];
            st.cfg2 <= SRC_CFG2_RST;
            st.rdata <= 32'h00000000;
        end
        else
        begin
            st <= next_st;
        end
    end

    // waitrequest drops in the answer cycle
    assign avs_waitrequest = (st.bus != SRC_BUS_ACK);
    assign avs_readdata = st.rdata;
    assign ext_int_sel_o = {st.ext_b, st.ext_a};
    assign cfg2_o = st.cfg2;

    // memory placed at address zero
    src_mem_decode u_mem (
        .map_i(st.remap[SRC_B_MAP +: 2]),
        .mem_o(mem_at_zero_o)
    );

    // converter and first serial port routes
    src_dma_route #(
        .CH_CLEAR(3'h1),
        .CH_SET(3'h2)
    ) u_conv (
        .remap_i(st.remap[SRC_B_CONV]),
        .channel_o(conv_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h2),
        .CH_SET(3'h4)
    ) u_ser1a (
        .remap_i(st.remap[SRC_B_SER1_A]),
        .channel_o(ser1_a_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h3),
        .CH_SET(3'h5)
    ) u_ser1b (
        .remap_i(st.remap[SRC_B_SER1_B]),
        .channel_o(ser1_b_ch_o)
    );

    // plain timer routes, overridden by the alternate bits below
    src_dma_route #(
        .CH_CLEAR(3'h3),
        .CH_SET(3'h4)
    ) u_t16 (
        .remap_i(st.remap[SRC_B_T16]),
        .channel_o(t16_plain)
    );

    src_dma_route #(
        .CH_CLEAR(3'h1),
        .CH_SET(3'h2)
    ) u_t17 (
        .remap_i(st.remap[SRC_B_T17]),
        .channel_o(t17_plain)
    );

    // second spi, one bit moves both directions
    src_dma_route #(
        .CH_CLEAR(3'h4),
        .CH_SET(3'h6)
    ) u_spi2r (
        .remap_i(st.remap[SRC_B_SPI2]),
        .channel_o(spi2_rx_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h5),
        .CH_SET(3'h7)
    ) u_spi2t (
        .remap_i(st.remap[SRC_B_SPI2]),
        .channel_o(spi2_tx_ch_o)
    );

    // second and third serial ports
    src_dma_route #(
        .CH_CLEAR(3'h5),
        .CH_SET(3'h6)
    ) u_ser2r (
        .remap_i(st.remap[SRC_B_SER2]),
        .channel_o(ser2_rx_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h4),
        .CH_SET(3'h7)
    ) u_ser2t (
        .remap_i(st.remap[SRC_B_SER2]),
        .channel_o(ser2_tx_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h6),
        .CH_SET(3'h3)
    ) u_ser3r (
        .remap_i(st.remap[SRC_B_SER3]),
        .channel_o(ser3_rx_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h7),
        .CH_SET(3'h2)
    ) u_ser3t (
        .remap_i(st.remap[SRC_B_SER3]),
        .channel_o(ser3_tx_ch_o)
    );

    // first i2c controller
    src_dma_route #(
        .CH_CLEAR(3'h3),
        .CH_SET(3'h7)
    ) u_i2cr (
        .remap_i(st.remap[SRC_B_I2C1]),
        .channel_o(i2c1_rx_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h2),
        .CH_SET(3'h6)
    ) u_i2ct (
        .remap_i(st.remap[SRC_B_I2C1]),
        .channel_o(i2c1_tx_ch_o)
    );

    // timer capture routes, set bit gathers them on one channel
    src_dma_route #(
        .CH_CLEAR(3'h2),
        .CH_SET(3'h6)
    ) u_t1a (
        .remap_i(st.remap[SRC_B_T1]),
        .channel_o(t1_ch1_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h3),
        .CH_SET(3'h6)
    ) u_t1b (
        .remap_i(st.remap[SRC_B_T1]),
        .channel_o(t1_ch2_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h4),
        .CH_SET(3'h6)
    ) u_t1c (
        .remap_i(st.remap[SRC_B_T1]),
        .channel_o(t1_ch3_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h3),
        .CH_SET(3'h7)
    ) u_t2a (
        .remap_i(st.remap[SRC_B_T2]),
        .channel_o(t2_ch2_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h4),
        .CH_SET(3'h7)
    ) u_t2b (
        .remap_i(st.remap[SRC_B_T2]),
        .channel_o(t2_ch4_ch_o)
    );

    src_dma_route #(
        .CH_CLEAR(3'h4),
        .CH_SET(3'h6)
    ) u_t3 (
        .remap_i(st.remap[SRC_B_T3]),
        .channel_o(t3_ch_o)
    );

    // alternate remaps take priority over the plain ones
    assign t16_ch_o = st.remap[SRC_B_T16_ALT] ? 3'h6 : t16_plain;
    assign t17_ch_o = st.remap[SRC_B_T17_ALT] ? 3'h7 : t17_plain;

    // fast-mode-plus drive enables
    assign pin_b_fast_plus_o = st.remap[SRC_B_PIN_FP +: 4];
    assign i2c_first_fast_plus_all_o = st.remap[SRC_B_I2C1_FP];
    assign i2c_second_fast_plus_all_o = st.remap[SRC_B_I2C2_FP];
endmodule
`default_nettype wire

/* test/src_remap_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// bus and routing checks at the remap block ports
module src_remap_chk
    import src_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire src_mem_t mem_at_zero_o,
    input wire logic [2:0] conv_ch_o,
    input wire logic [2:0] t16_ch_o,
    input wire logic [2:0] t17_ch_o,
    input wire logic [2:0] spi2_rx_ch_o,
    input wire logic [2:0] spi2_tx_ch_o,
    input wire logic [2:0] t1_ch1_ch_o,
    input wire logic [2:0] t1_ch3_ch_o,
    input wire logic [2:0] t3_ch_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // accepted cycles on the remap register
    logic wr_ok, rd_ok;
    assign wr_ok = avs_write && !avs_waitrequest && avs_address == SRC_OFF_REMAP;
    assign rd_ok = avs_read && !avs_waitrequest && avs_address == SRC_OFF_REMAP;
    chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_ack_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    chk_map_write: assert property (wr_ok && avs_byteenable[0] |-> mem_at_zero_o ==
        (!avs_writedata[0] ? SRC_MEM_MAIN_FLASH : avs_writedata[1] ? SRC_MEM_SRAM
        : SRC_MEM_SYS_FLASH)) else $error("memory map not from write");
    chk_rsvd_zero: assert property (rd_ok |-> (avs_readdata & ~SRC_REMAP_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    chk_conv_route: assert property (conv_ch_o inside {3'h1, 3'h2})
        else $error("converter channel bad");
    chk_t16_route: assert property (t16_ch_o inside {3'h3, 3'h4, 3'h6})
        else $error("timer16 channel bad");
    chk_t17_route: assert property (t17_ch_o inside {3'h1, 3'h2, 3'h7})
        else $error("timer17 channel bad");
    chk_spi2_pair: assert property (spi2_tx_ch_o == spi2_rx_ch_o + 3'h1
        && spi2_rx_ch_o inside {3'h4, 3'h6}) else $error("spi2 channels bad");
    chk_t1_group: assert property ((t1_ch1_ch_o == 3'h6) ? (t1_ch3_ch_o == 3'h6)
        : (t1_ch1_ch_o == 3'h2 && t1_ch3_ch_o == 3'h4)) else $error("timer1 channels bad");
    chk_t3_route: assert property (t3_ch_o inside {3'h4, 3'h6})
        else $error("timer3 channel bad");
    cover property (wr_ok);
    cover property (rd_ok);
    cover property (t16_ch_o == 3'h6);
endmodule
`default_nettype wire

/* test/src_system_remap_config_test.sv */
`timescale 1ns/10ps
`default_nettype none
module src_system_remap_config_test
    import src_pkg::*;
;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [1:0] boot_map_i = 2'h3;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, ext_int_sel_o, cfg2_o, rd, r;
    logic avs_waitrequest, i2c_first_fast_plus_all_o, i2c_second_fast_plus_all_o;
    src_mem_t mem_at_zero_o;
    logic [2:0] conv_ch_o, ser1_a_ch_o, ser1_b_ch_o, t16_ch_o, t17_ch_o, spi2_rx_ch_o;
    logic [2:0] spi2_tx_ch_o, ser2_rx_ch_o, ser2_tx_ch_o, ser3_rx_ch_o, ser3_tx_ch_o;
    logic [2:0] i2c1_rx_ch_o, i2c1_tx_ch_o, t1_ch1_ch_o, t1_ch2_ch_o, t1_ch3_ch_o;
    logic [2:0] t2_ch2_ch_o, t2_ch4_ch_o, t3_ch_o;
    logic [3:0] pin_b_fast_plus_o;
    logic [56:0] chans;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    // write value beside expected readback
    logic [63:0] rows [8] = '{64'h00000000_00000000, 64'hffffffff_7f3f7f03,
        64'h80c08802_00000802, 64'h00002801_00002801, 64'h00005000_00005000,
        64'h00001103_00001103, 64'h55555555_55155501, 64'haaaaaaaa_2a2a2a02};
    src_system_remap_config dut (
        .clk_i, .arst_n_i, .boot_map_i, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .mem_at_zero_o, .conv_ch_o, .ser1_a_ch_o, .ser1_b_ch_o, .t16_ch_o, .t17_ch_o,
        .spi2_rx_ch_o, .spi2_tx_ch_o, .ser2_rx_ch_o, .ser2_tx_ch_o, .ser3_rx_ch_o,
        .ser3_tx_ch_o, .i2c1_rx_ch_o, .i2c1_tx_ch_o, .t1_ch1_ch_o, .t1_ch2_ch_o,
        .t1_ch3_ch_o, .t2_ch2_ch_o, .t2_ch4_ch_o, .t3_ch_o, .pin_b_fast_plus_o,
        .i2c_first_fast_plus_all_o, .i2c_second_fast_plus_all_o, .ext_int_sel_o, .cfg2_o
    );
    // all channel numbers in one word
    assign chans = {conv_ch_o, ser1_a_ch_o, ser1_b_ch_o, t16_ch_o, t17_ch_o, spi2_rx_ch_o,
        spi2_tx_ch_o, ser2_rx_ch_o, ser2_tx_ch_o, ser3_rx_ch_o, ser3_tx_ch_o, i2c1_rx_ch_o,
        i2c1_tx_ch_o, t1_ch1_ch_o, t1_ch2_ch_o, t1_ch3_ch_o, t2_ch2_ch_o, t2_ch4_ch_o, t3_ch_o};
    always #10 clk_i = ~clk_i;
    // expected routes for a register value
    function automatic logic [56:0] exp_ch(input logic [31:0] v);
        logic [2:0] a, b;
        a = v[13] ? 3'h6 : (v[11] ? 3'h4 : 3'h3);
        b = v[14] ? 3'h7 : (v[12] ? 3'h2 : 3'h1);
        return {v[8] ? 3'h2 : 3'h1, v[9] ? 3'h4 : 3'h2, v[10] ? 3'h5 : 3'h3, a, b,
            v[24] ? 6'h37 : 6'h25, v[25] ? 6'h37 : 6'h2c, v[26] ? 6'h1a : 6'h37,
            v[27] ? 6'h3e : 6'h1a, v[28] ? 9'h1b6 : 9'h09c, v[29] ? 6'h3f : 6'h1c,
            v[30] ? 3'h6 : 3'h4};
    endfunction
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_i);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog on run length
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check("boot map", mem_at_zero_o, SRC_MEM_SRAM);
        check("reset routes", chans, exp_ch(32'h0));
        bus(1'b0, SRC_OFF_REMAP, 32'h0, 4'hf);
        check("remap reset", rd, 32'h00000003);
        bus(1'b0, SRC_OFF_CFG2, 32'h0, 4'hf);
        check("cfg2 reset", rd, SRC_CFG2_RST);
        foreach (rows[i])
        begin
            bus(1'b1, SRC_OFF_REMAP, rows[i][63:32], 4'hf);
            bus(1'b0, SRC_OFF_REMAP, 32'h0, 4'hf);
            r = rows[i][31:0];
            @(negedge clk_i);
            check("remap readback", rd, r);
            check("channels", chans, exp_ch(r));
            check("memory map", mem_at_zero_o, !r[0] ? SRC_MEM_MAIN_FLASH :
                r[1] ? SRC_MEM_SRAM : SRC_MEM_SYS_FLASH);
            check("fast plus", {i2c_second_fast_plus_all_o, i2c_first_fast_plus_all_o,
                pin_b_fast_plus_o}, r[21:16]);
        end
        bus(1'b1, SRC_OFF_REMAP, 32'h0, 4'hf);
        bus(1'b1, SRC_OFF_REMAP, 32'hffffffff, 4'h2);
        bus(1'b1, 5'h04, 32'hffffffff, 4'hf);
        bus(1'b0, 5'h04, 32'h0, 4'hf);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, SRC_OFF_REMAP, 32'h0, 4'hf);
        check("byte lane", rd, 32'h00007f00);
        bus(1'b1, SRC_OFF_EXTA, 32'hffffffff, 4'hf);
        bus(1'b1, SRC_OFF_EXTB, 32'h1234abcd, 4'hf);
        bus(1'b1, SRC_OFF_CFG2, 32'ha5a5c3c3, 4'hf);
        bus(1'b0, SRC_OFF_EXTA, 32'h0, 4'hf);
        check("ext read", rd, 32'h0000ffff);
        check("ext out", ext_int_sel_o, 32'habcdffff);
        check("cfg2 out", cfg2_o, 32'ha5a5c3c3);
        // remaining select words and partial byte lanes
        bus(1'b1, SRC_OFF_EXTC, 32'hffff1234, 4'hf);
        bus(1'b1, SRC_OFF_EXTD, 32'hffffffff, 4'h1);
        bus(1'b1, SRC_OFF_CFG2, 32'h00000000, 4'h8);
        bus(1'b0, SRC_OFF_EXTC, 32'h0, 4'hf);
        check("ext c read", rd, 32'h00001234);
        bus(1'b0, SRC_OFF_EXTD, 32'h0, 4'hf);
        check("ext d lane", rd, 32'h000000ff);
        bus(1'b0, SRC_OFF_CFG2, 32'h0, 4'hf);
        check("cfg2 lane", rd, 32'h00a5c3c3);
        // second reset with other boot levels
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        boot_map_i <= 2'h1;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        bus(1'b0, SRC_OFF_REMAP, 32'h0, 4'hf);
        check("remap reboot", rd, 32'h00000001);
        check("reboot map", mem_at_zero_o, SRC_MEM_SYS_FLASH);
        bus(1'b0, SRC_OFF_EXTD, 32'h0, 4'hf);
        check("ext reboot", rd, 32'h00000000);
        bus(1'b0, SRC_OFF_CFG2, 32'h0, 4'hf);
        check("cfg2 reboot", rd, SRC_CFG2_RST);
        tally_and_finish();
    end
endmodule
bind src_system_remap_config src_remap_chk chk (
    .clk_i, .arst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_at_zero_o, .conv_ch_o,
    .t16_ch_o, .t17_ch_o, .spi2_rx_ch_o, .spi2_tx_ch_o, .t1_ch1_ch_o, .t1_ch3_ch_o, .t3_ch_o
);
`default_nettype wire
